// ---- rtl/sssp_core.sv ----
// Notes on behaviour
// - Slave when sync, not clock master, enabled
// - Transmit direction only when both receive enables clear
// - Transmit needs enable; data write queues character
// - Nine-bit transmit sends stored ninth bit last
// - No address detection in synchronous modes
// - Interrupt needs own, peripheral and global enables
// - Continuous receive keeps receiver active until an overrun
// - Single receive enable ignored by slave reception
// - Completed character moves to receive buffer, even asleep
// - Receive-complete flag set at character end
// - Ninth received bit shown in status field
// - Clearing continuous receive clears overrun
// - Only slave mode shifts while asleep
// - Sleeping receive sets flag and wakes processor
// - Receive flag clears once buffer fully read
// - Wake resumes; vector 0004h when globally enabled
// - Data changes leading edge, sampled trailing edge
// - Two-deep receive buffer, third character overruns
// - Queued character moves after first; flag then sets
`timescale 1ns/10ps
module sssp_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Processor state
  input wire logic sleepIn,
  // Serial pins
  input wire logic clkPinIn,
  input wire logic dataPinIn,
  output logic dataPinOut,
  output logic dataPinOe,
  // Processor requests
  output logic irqReq,
  output logic wakeReq,
  output logic [12:0] isrAddr
);

  typedef struct packed {
    sssp_pkg::sssp_ctrl_t ctrl;
    logic [2:0] ckSync;
    logic [2:0] dtSync;
    logic ckLevel;
    logic dtLevel;
    logic [7:0] txBuf;
    logic txBufFull;
    sssp_pkg::sssp_txstate_t txState;
    logic [8:0] transmit_shifter;
    logic [3:0] txCnt;
    logic [8:0] receive_shifter;
    logic [3:0] rxCnt;
    logic [1:0][8:0] fifo;
    logic [1:0] fifoCnt;
    logic overrun;
    logic ack;
    logic [31:0] rdData;
    logic dtOut;
    logic dtOe;
    logic irq;
    logic wake;
    logic [12:0] vec;
  } sssp_state_t;

  logic [1:0] rstPipe_r;
  logic rstSync_b;
  sssp_state_t state_r;
  sssp_state_t state_nxt;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'b00;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe_r[1];

  logic slaveMode;
  logic txMode;
  logic rxMode;
  logic ckRise;
  logic ckFall;
  logic busTake;
  logic rxPop;
  logic rxPush;
  logic rxFlag;
  logic txFlag;
  logic [3:0] txLen;
  logic [3:0] rxLen;
  logic [8:0] rxChar;
  logic [1:0] cntWork;
  logic [7:0] rdMux;

  always_comb begin
    state_nxt = state_r;
    slaveMode = state_r.ctrl.syncMode && !state_r.ctrl.clkMaster && state_r.ctrl.portEn;
    // Direction: transmit only with both receive enables clear
    txMode = slaveMode && !state_r.ctrl.contRx && !state_r.ctrl.singleRx;
    // Single receive enable plays no part in slave reception
    rxMode = slaveMode && state_r.ctrl.contRx && !state_r.overrun;
    txLen = state_r.ctrl.txNine ? sssp_pkg::CHAR_BITS_9 : sssp_pkg::CHAR_BITS_8;
    rxLen = state_r.ctrl.rxNine ? sssp_pkg::CHAR_BITS_9 : sssp_pkg::CHAR_BITS_8;

    // Pin inputs: three flops, a level counts once stages two and three agree
    state_nxt.ckSync = {state_r.ckSync[1:0], clkPinIn};
    state_nxt.dtSync = {state_r.dtSync[1:0], dataPinIn};
    if (state_r.ckSync[1] == state_r.ckSync[2]) begin
      state_nxt.ckLevel = state_r.ckSync[2];
    end
    if (state_r.dtSync[1] == state_r.dtSync[2]) begin
      state_nxt.dtLevel = state_r.dtSync[2];
    end
    // Shifting runs only on edges from the external clock
    ckRise = (state_nxt.ckLevel && !state_r.ckLevel) && slaveMode;
    ckFall = (!state_nxt.ckLevel && state_r.ckLevel) && slaveMode;

    // Avalon access: one wait state, the answer is registered
    busTake = (read || write) && state_r.ack;
    state_nxt.ack = (read || write) && !state_r.ack;
    rxPop = busTake && read && (address == sssp_pkg::OFS_RX_DATA) && (state_r.fifoCnt != 2'h0);

    if (busTake && write) begin
      unique case (address)
        sssp_pkg::OFS_IRQ_ENABLE: begin
          state_nxt.ctrl.rxIe = writedata[sssp_pkg::BIT_RX_IRQ];
          state_nxt.ctrl.transmit_interrupt_enable = writedata[sssp_pkg::BIT_TX_IRQ];
        end
        sssp_pkg::OFS_RX_STATUS: begin
          state_nxt.ctrl.portEn = writedata[sssp_pkg::BIT_PORT_EN];
          state_nxt.ctrl.rxNine = writedata[sssp_pkg::BIT_RX_NINE];
          state_nxt.ctrl.singleRx = writedata[sssp_pkg::BIT_SINGLE_RX];
          state_nxt.ctrl.contRx = writedata[sssp_pkg::BIT_CONT_RX];
          // Stored for software only; no matching logic exists
          state_nxt.ctrl.addrDet = writedata[sssp_pkg::BIT_ADDR_DET];
        end
        sssp_pkg::OFS_TX_DATA: begin
          state_nxt.txBuf = writedata[7:0];
          state_nxt.txBufFull = 1'b1;
        end
        sssp_pkg::OFS_TX_STATUS: begin
          state_nxt.ctrl.clkMaster = writedata[sssp_pkg::BIT_CLK_MASTER];
          state_nxt.ctrl.txNine = writedata[sssp_pkg::BIT_TX_NINE];
          state_nxt.ctrl.transmit_enable = writedata[sssp_pkg::BIT_TX_EN];
          state_nxt.ctrl.syncMode = writedata[sssp_pkg::BIT_SYNC_MODE];
          state_nxt.ctrl.highRate = writedata[sssp_pkg::BIT_HIGH_RATE];
          state_nxt.ctrl.txNinth = writedata[sssp_pkg::BIT_TX_NINTH];
        end
        sssp_pkg::OFS_CORE_CTRL: begin
          state_nxt.ctrl.globalIe = writedata[sssp_pkg::BIT_GLOBAL_IE];
          state_nxt.ctrl.periphIe = writedata[sssp_pkg::BIT_PERIPH_IE];
        end
        default: begin
        end
      endcase
    end

    // Overrun ends with continuous receive cleared or slave mode left
    if (!state_r.ctrl.contRx) begin
      state_nxt.overrun = 1'b0;
    end

    // Transmit shifter
    unique case (state_r.txState)
      sssp_pkg::TXS_EMPTY: begin
        if (txMode && state_r.ctrl.transmit_enable && state_r.txBufFull) begin
          state_nxt.transmit_shifter = {state_r.ctrl.txNine && state_r.ctrl.txNinth, state_r.txBuf};
          state_nxt.txBufFull = 1'b0;
          state_nxt.txCnt = 4'h0;
          state_nxt.txState = sssp_pkg::TXS_BUSY;
        end
      end
      sssp_pkg::TXS_BUSY: begin
        if (!txMode || !state_r.ctrl.transmit_enable) begin
          state_nxt.txState = sssp_pkg::TXS_EMPTY;
        end else begin
          if (ckRise) begin
            state_nxt.dtOut = state_r.transmit_shifter[0];
            state_nxt.transmit_shifter = {1'b0, state_r.transmit_shifter[8:1]};
          end
          if (ckFall) begin
            state_nxt.txCnt = state_r.txCnt + 4'h1;
            // Character ends on the trailing edge of its last bit
            if (state_r.txCnt + 4'h1 == txLen) begin
              state_nxt.txState = sssp_pkg::TXS_EMPTY;
            end
          end
        end
      end
    endcase
    state_nxt.dtOe = txMode && state_r.ctrl.transmit_enable;

    // Receive shifter: sample on the trailing edge, fill from the top
    rxPush = 1'b0;
    rxChar = 9'h000;
    if (!rxMode) begin
      state_nxt.rxCnt = 4'h0;
    end else if (ckFall) begin
      state_nxt.receive_shifter = {state_r.dtLevel, state_r.receive_shifter[8:1]};
      state_nxt.rxCnt = state_r.rxCnt + 4'h1;
      if (state_r.rxCnt + 4'h1 == rxLen) begin
        state_nxt.rxCnt = 4'h0;
        rxPush = 1'b1;
        rxChar = state_r.ctrl.rxNine ? state_nxt.receive_shifter : {1'b0, state_nxt.receive_shifter[8:1]};
      end
    end

    // Two-entry receive buffer, top entry at index zero
    cntWork = state_r.fifoCnt;
    if (rxPop) begin
      state_nxt.fifo[0] = state_r.fifo[1];
      cntWork = cntWork - 2'h1;
    end
    if (rxPush) begin
      if (cntWork == sssp_pkg::RX_DEPTH) begin
        // Third character is dropped; buffered data stays intact
        state_nxt.overrun = 1'b1;
      end else begin
        state_nxt.fifo[cntWork[0]] = rxChar;
        cntWork = cntWork + 2'h1;
      end
    end
    state_nxt.fifoCnt = cntWork;

    // Leaving slave mode drops everything in flight except a character queued in the transmit buffer
    if (!slaveMode) begin
      state_nxt.txState = sssp_pkg::TXS_EMPTY;
      state_nxt.overrun = 1'b0;
      state_nxt.fifoCnt = 2'h0;
    end

    // Flags follow buffer state, so no clear can race a set
    rxFlag = state_r.fifoCnt != 2'h0;
    txFlag = state_r.ctrl.transmit_enable && !state_r.txBufFull;
    state_nxt.wake = state_r.ctrl.periphIe &&
                     ((rxFlag && state_r.ctrl.rxIe) || (txFlag && state_r.ctrl.transmit_interrupt_enable));
    state_nxt.irq = state_nxt.wake && state_r.ctrl.globalIe;
    state_nxt.vec = state_nxt.irq ? sssp_pkg::ISR_VECTOR : 13'h0000;

    // Read answer
    rdMux = sssp_pkg::RST_REG;
    unique case (address)
      sssp_pkg::OFS_IRQ_ENABLE: begin
        rdMux[sssp_pkg::BIT_RX_IRQ] = state_r.ctrl.rxIe;
        rdMux[sssp_pkg::BIT_TX_IRQ] = state_r.ctrl.transmit_interrupt_enable;
      end
      sssp_pkg::OFS_IRQ_FLAGS: begin
        rdMux[sssp_pkg::BIT_RX_IRQ] = rxFlag;
        rdMux[sssp_pkg::BIT_TX_IRQ] = txFlag;
      end
      sssp_pkg::OFS_RX_STATUS: begin
        rdMux[sssp_pkg::BIT_PORT_EN] = state_r.ctrl.portEn;
        rdMux[sssp_pkg::BIT_RX_NINE] = state_r.ctrl.rxNine;
        rdMux[sssp_pkg::BIT_SINGLE_RX] = state_r.ctrl.singleRx;
        rdMux[sssp_pkg::BIT_CONT_RX] = state_r.ctrl.contRx;
        rdMux[sssp_pkg::BIT_ADDR_DET] = state_r.ctrl.addrDet;
        rdMux[sssp_pkg::BIT_OVERRUN] = state_r.overrun;
        rdMux[sssp_pkg::BIT_RX_NINTH] = state_r.fifo[0][8];
      end
      sssp_pkg::OFS_TX_STATUS: begin
        rdMux[sssp_pkg::BIT_CLK_MASTER] = state_r.ctrl.clkMaster;
        rdMux[sssp_pkg::BIT_TX_NINE] = state_r.ctrl.txNine;
        rdMux[sssp_pkg::BIT_TX_EN] = state_r.ctrl.transmit_enable;
        rdMux[sssp_pkg::BIT_SYNC_MODE] = state_r.ctrl.syncMode;
        rdMux[sssp_pkg::BIT_HIGH_RATE] = state_r.ctrl.highRate;
        rdMux[sssp_pkg::BIT_SHIFTER_EMPTY] = state_r.txState == sssp_pkg::TXS_EMPTY;
        rdMux[sssp_pkg::BIT_TX_NINTH] = state_r.ctrl.txNinth;
      end
      sssp_pkg::OFS_RX_DATA: begin
        rdMux = state_r.fifo[0][7:0];
      end
      sssp_pkg::OFS_CORE_CTRL: begin
        rdMux[sssp_pkg::BIT_GLOBAL_IE] = state_r.ctrl.globalIe;
        rdMux[sssp_pkg::BIT_PERIPH_IE] = state_r.ctrl.periphIe;
      end
      default: begin
      end
    endcase
    if (read && !state_r.ack) begin
      state_nxt.rdData = {24'h00_0000, rdMux};
    end
  end

  always_ff @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state_r <= '{txState: sssp_pkg::TXS_EMPTY, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign readdata = state_r.rdData;
  assign waitrequest = !state_r.ack;
  assign dataPinOut = state_r.dtOut;
  assign dataPinOe = state_r.dtOe;
  assign irqReq = state_r.irq;
  assign wakeReq = state_r.wake;
  assign isrAddr = state_r.vec;

  // Checks
  // Leaving slave mode must drop the shifting and buffered characters; a queued transmit character is not checked
  a_mode_gate: assert property (@(posedge mclk) disable iff (!rstSync_b)
    !slaveMode |=> (state_r.txState == sssp_pkg::TXS_EMPTY && state_r.fifoCnt == 2'h0 &&
    state_r.rxCnt == 4'h0)) else $error("state kept outside slave mode");

  a_sleep_halt: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (sleepIn && !slaveMode) |=> ($stable(state_r.receive_shifter) && $stable(state_r.transmit_shifter)))
    else $error("shifter moved while asleep outside slave mode");

  a_tx_direction: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.ctrl.contRx || state_r.ctrl.singleRx) |=> !state_r.dtOe)
    else $error("data pin driven while receiving");

  a_oe_follows: assert property (@(posedge mclk) disable iff (!rstSync_b)
    state_r.dtOe |-> $past(txMode && state_r.ctrl.transmit_enable))
    else $error("data pin driven outside slave transmit");

  a_tx_needs_en: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.txState == sssp_pkg::TXS_EMPTY && !state_r.ctrl.transmit_enable) |=>
    state_r.txState == sssp_pkg::TXS_EMPTY) else $error("shifter loaded without enable");

  a_ninth_load: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.txState == sssp_pkg::TXS_EMPTY && state_nxt.txState == sssp_pkg::TXS_BUSY) |=>
    state_r.transmit_shifter[8] == $past(state_r.ctrl.txNine && state_r.ctrl.txNinth))
    else $error("ninth transmit bit wrong");

  a_lsb_first: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.txState == sssp_pkg::TXS_BUSY && txMode && state_r.ctrl.transmit_enable && ckRise) |=>
    state_r.dtOut == $past(state_r.transmit_shifter[0])) else $error("transmit bit out of order");

  a_irq_gate: assert property (@(posedge mclk) disable iff (!rstSync_b)
    state_r.irq |-> $past(state_r.ctrl.globalIe) && $past(state_r.ctrl.periphIe))
    else $error("interrupt without enables");

  a_rx_ignores_single: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (slaveMode && !state_r.ctrl.contRx) |=> state_r.rxCnt == 4'h0)
    else $error("receiver counted without continuous enable");

  a_push_flag: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (rxPush && slaveMode && !rxPop) |=> state_r.fifoCnt != 2'h0)
    else $error("receive flag not set after character");

  a_rx_ninth_out: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (rxPush && state_r.fifoCnt == 2'h0) |=>
    state_r.fifo[0][8] == ($past(state_r.ctrl.rxNine) && $past(state_r.dtLevel)))
    else $error("received ninth bit wrong");

  a_overrun_clear: assert property (@(posedge mclk) disable iff (!rstSync_b)
    !state_r.ctrl.contRx |=> !state_r.overrun) else $error("overrun survived enable clear");

  a_overrun_keep: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (rxPush && state_r.fifoCnt == sssp_pkg::RX_DEPTH && !rxPop && state_r.ctrl.contRx) |=>
    state_r.overrun && $stable(state_r.fifo)) else $error("overrun lost or overwrote");

  a_tx_queue_hold: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.txState == sssp_pkg::TXS_BUSY && state_r.txBufFull) |=> state_r.txBufFull)
    else $error("queued character left before shifter emptied");

  a_wake_flag: assert property (@(posedge mclk) disable iff (!rstSync_b)
    (state_r.fifoCnt != 2'h0 && state_r.ctrl.rxIe && state_r.ctrl.periphIe) |=> state_r.wake)
    else $error("no wake with pending character");

  a_vector_addr: assert property (@(posedge mclk) disable iff (!rstSync_b)
    state_r.irq |-> isrAddr == sssp_pkg::ISR_VECTOR) else $error("wrong interrupt vector");

endmodule : sssp_core

// ---- rtl/sssp_pkg.sv ----
package sssp_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h00;
  localparam logic [4:0] OFS_IRQ_FLAGS = 5'h04;
  localparam logic [4:0] OFS_RX_STATUS = 5'h08;
  localparam logic [4:0] OFS_TX_DATA = 5'h0C;
  localparam logic [4:0] OFS_TX_STATUS = 5'h10;
  localparam logic [4:0] OFS_RX_DATA = 5'h14;
  localparam logic [4:0] OFS_CORE_CTRL = 5'h18;
  // Interrupt enable / flag bit positions
  localparam int BIT_RX_IRQ = 5;
  localparam int BIT_TX_IRQ = 4;
  // Receive status/control bit positions
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_RX_NINE = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX = 4;
  localparam int BIT_ADDR_DET = 3;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_NINTH = 0;
  // Transmit status/control bit positions
  localparam int BIT_CLK_MASTER = 7;
  localparam int BIT_TX_NINE = 6;
  localparam int BIT_TX_EN = 5;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_HIGH_RATE = 2;
  localparam int BIT_SHIFTER_EMPTY = 1;
  localparam int BIT_TX_NINTH = 0;
  // Core control bit positions
  localparam int BIT_GLOBAL_IE = 7;
  localparam int BIT_PERIPH_IE = 6;
  // Reset values and constants
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [12:0] ISR_VECTOR = 13'h0004;
  localparam logic [3:0] CHAR_BITS_8 = 4'h8;
  localparam logic [3:0] CHAR_BITS_9 = 4'h9;
  localparam logic [1:0] RX_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    TXS_EMPTY = 2'b01,
    TXS_BUSY = 2'b10
  } sssp_txstate_t;

  typedef struct packed {
    logic portEn;
    logic rxNine;
    logic singleRx;
    logic contRx;
    logic addrDet;
    logic clkMaster;
    logic txNine;
    logic transmit_enable;
    logic syncMode;
    logic highRate;
    logic txNinth;
    logic rxIe;
    logic transmit_interrupt_enable;
    logic globalIe;
    logic periphIe;
  } sssp_ctrl_t;
endpackage : sssp_pkg

// ---- sim/serial_sync_slave_port_test.sv ----
`timescale 1ns/10ps
module serial_sync_slave_port_test;
  logic mclk = 1'b0;
  logic rst_b, read, write, sleepIn;
  logic [4:0] address;
  logic [31:0] writedata, readdata;
  logic waitrequest, dataPinOut, dataPinOe, irqReq, wakeReq, lineOut, clkPin, dataWire;
  logic [12:0] isrAddr;
  logic [8:0] rx;
  logic [7:0] rd;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;
  // Shared data wire: the slave wins while it drives
  assign dataWire = dataPinOe ? dataPinOut : lineOut;

  sssp_core uut (
    .mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sleepIn(sleepIn), .clkPinIn(clkPin), .dataPinIn(dataWire), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .irqReq(irqReq), .wakeReq(wakeReq), .isrAddr(isrAddr)
  );
  sssp_link_master link (.clkPin(clkPin), .lineOut(lineOut), .lineIn(dataWire));

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= ~wr;
    write <= wr;
    // Only the bench timeout ends a wait that never sees an answer
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({5'h00, rd}, {5'h00, e});
  endtask : rdChk

  // Lets a finished frame pass the pin synchroniser and reach the flags
  task automatic settle;
    repeat (8) @(posedge mclk);
  endtask : settle

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results;
    end
  end

  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    sleepIn = 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values, including the unmapped hole at the top
    for (int a = 0; a < 32; a += 4)
      rdChk(5'(a), (5'(a) == sssp_pkg::OFS_TX_STATUS) ? 8'h02 : 8'h00);

    // Receive while asleep, single receive set as well
    sleepIn <= 1'b1;
    bus(1'b1, sssp_pkg::OFS_IRQ_ENABLE, 8'h20);
    bus(1'b1, sssp_pkg::OFS_CORE_CTRL, 8'hC0);
    bus(1'b1, sssp_pkg::OFS_TX_STATUS, 8'h10);
    bus(1'b1, sssp_pkg::OFS_RX_STATUS, 8'hB0);
    link.frame(8, 9'h0A5, rx);
    settle;
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0006);
    check(isrAddr, 13'h0004);
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h20);
    rdChk(sssp_pkg::OFS_RX_DATA, 8'hA5);
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h00);
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0000);

    // Three characters with nothing read: the third is dropped
    for (int i = 1; i < 4; i++)
      link.frame(8, 9'(i * 17), rx);
    settle;
    rdChk(sssp_pkg::OFS_RX_STATUS, 8'hB2);
    rdChk(sssp_pkg::OFS_RX_DATA, 8'h11);
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h20);
    rdChk(sssp_pkg::OFS_RX_DATA, 8'h22);
    bus(1'b1, sssp_pkg::OFS_RX_STATUS, 8'h80);
    rdChk(sssp_pkg::OFS_RX_STATUS, 8'h80);

    // Nine-bit receive with the global enable off: wake but no vector
    bus(1'b1, sssp_pkg::OFS_CORE_CTRL, 8'h40);
    bus(1'b1, sssp_pkg::OFS_RX_STATUS, 8'hD0);
    link.frame(9, 9'h1C4, rx);
    settle;
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0002);
    check(isrAddr, 13'h0000);
    rdChk(sssp_pkg::OFS_RX_STATUS, 8'hD1);
    rdChk(sssp_pkg::OFS_RX_DATA, 8'hC4);

    // Nine-bit transmit of two queued characters
    bus(1'b1, sssp_pkg::OFS_RX_STATUS, 8'h80);
    bus(1'b1, sssp_pkg::OFS_IRQ_ENABLE, 8'h10);
    bus(1'b1, sssp_pkg::OFS_TX_STATUS, 8'h71);
    bus(1'b1, sssp_pkg::OFS_TX_DATA, 8'h3C);
    bus(1'b1, sssp_pkg::OFS_TX_DATA, 8'h5A);
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h00);
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0001);
    link.frame(9, 9'h000, rx);
    check({4'h0, rx}, 13'h013C);
    settle;
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h10);
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0003);
    link.frame(9, 9'h000, rx);
    check({4'h0, rx}, 13'h015A);
    settle;
    rdChk(sssp_pkg::OFS_TX_STATUS, 8'h73);

    // Leaving slave mode flushes a buffered character and stops reception
    bus(1'b1, sssp_pkg::OFS_RX_STATUS, 8'h90);
    link.frame(8, 9'h0E7, rx);
    settle;
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h30);
    bus(1'b1, sssp_pkg::OFS_TX_STATUS, 8'h90);
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h00);
    link.frame(8, 9'h0E7, rx);
    settle;
    rdChk(sssp_pkg::OFS_IRQ_FLAGS, 8'h00);
    check({10'h000, irqReq, wakeReq, dataPinOe}, 13'h0000);
    results;
  end
endmodule : serial_sync_slave_port_test

// ---- sim/sssp_link_master.sv ----
`timescale 1ns/10ps
module sssp_link_master (
  // Link pins
  output logic clkPin,
  output logic lineOut,
  input wire logic lineIn
);
  initial begin
    clkPin = 1'b0;
    lineOut = 1'b1;
  end

  // Clock stands low between frames; a released line shows the inverse of its last bit
  task automatic frame(input int n, input logic [8:0] txw, output logic [8:0] rxw);
    rxw = 9'h000;
    // Start off the system clock edge so no pin change races the sampling flops
    #3;
    for (int i = 0; i < n; i++) begin
      clkPin = 1'b1;
      lineOut = txw[i];
      #40;
      clkPin = 1'b0;
      // The slave's pin synchroniser makes its bit late, so take it at the end of the cycle
      #39;
      rxw[i] = lineIn;
      #1;
    end
    lineOut = ~lineOut;
  endtask : frame
endmodule : sssp_link_master
